/* File: bench/asc_host_model.sv */
// Host side model: drives select, serial clock and data in.
// Assumes ref_clk is the bench clock; one serial bit every 32 cycles.
`timescale 1ns/1ps
module asc_host_model (
  // Clock
  input  wire logic ref_clk,
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Select, then let the pin synchronisers settle
  task sel();
    @(negedge ref_clk) cs_n = 1'b0;
    repeat (6) @(negedge ref_clk);
  endtask : sel
  // Hold select past the last clock, release, scramble the data line
  task desel();
    repeat (8) @(negedge ref_clk);
    cs_n = 1'b1;
    din  = ~din;
    repeat (6) @(negedge ref_clk);
  endtask : desel
  // One bit: data moves mid low phase, then rise and fall; 160 ns period
  task bit_out(input logic b);
    repeat (8) @(negedge ref_clk);
    din = b;
    repeat (8) @(negedge ref_clk);
    sclk = 1'b1;
    repeat (16) @(negedge ref_clk);
    sclk = 1'b0;
  endtask : bit_out
  // Whole byte, MSB first
  task byte_out(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      bit_out(v[i]);
    end
  endtask : byte_out
endmodule : asc_host_model

/* File: bench/test_afe_serial_control_port.sv */
// Self-checking bench for the serial control port.
// Assumes asc_pkg and asc_port are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
  $display("Error at %0t ns: got %0h want %0h", $time, a, e); end end
module test_afe_serial_control_port
  import asc_pkg::*;
  ;
  logic        ref_clk, sys_rst, conv_done, a1_drv, a2_drv, e;
  logic        cs_n, sclk, din, dout_o, dout_oe, rdy_n, dout_line;
  logic        a1_pin, a1_o, a1_oe, a2_pin, a2_o, a2_oe, cont;
  logic        src, mod_on, demod_on, freq, ref_int, pwr;
  logic [2:0]  thr;
  logic [4:0]  flags;
  logic [7:0]  cfg2, sense, rb1, rb2, rd;
  logic [23:0] ch1, ch2;
  logic [71:0] fr;
  logic        exp_q[$];
  int          n_fail = 0;
  int          n_compared = 0;
  int unsigned seed_v;
  assign a1_pin    = a1_oe ? a1_o : a1_drv;
  assign a2_pin    = a2_oe ? a2_o : a2_drv;
  assign dout_line = dout_oe ? dout_o : ~dout_o;
  asc_host_model i_host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk),
                         .din(din));
  asc_port i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout_o(dout_o), .dout_oe(dout_oe),
    .sample_ready_n(rdy_n), .conv_done(conv_done),
    .chan_one_data(ch1), .chan_two_data(ch2), .electrode_off_flags(flags),
    .aux_pin_one_i(a1_pin), .aux_pin_one_o(a1_o), .aux_pin_one_oe(a1_oe),
    .aux_pin_two_i(a2_pin), .aux_pin_two_o(a2_o), .aux_pin_two_oe(a2_oe),
    .breath_clock_source(src), .breath_modulator_on(mod_on),
    .breath_demodulator_on(demod_on), .breath_mod_freq_sel(freq),
    .drive_ref_internal_sel(ref_int), .drive_amp_power_on(pwr),
    .electrode_off_threshold(thr), .config_two(cfg2),
    .electrode_off_sense_sel(sense), .cont_read_active(cont));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task close_out();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #200000;
    n_fail++;
    $display("Error at %0t ns: watchdog expired", $time);
    close_out();
  end
  // Frame bits are checked as the host samples them
  always @(negedge sclk) begin
    if (!cs_n && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK(dout_line, e)
    end
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d0,
                    input logic [7:0] d1, input logic two);
    i_host.sel();
    i_host.byte_out({OP_WRITE_HEAD, a});
    i_host.byte_out({7'h00, two});
    i_host.byte_out(d0);
    if (two) begin
      i_host.byte_out(d1);
    end
    i_host.desel();
  endtask : wr
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst   = 1'b1;
    conv_done = 1'b0;
    {ch1, ch2, flags, a1_drv, a2_drv} = '0;
    seed_v = $urandom(75941);
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(dout_oe, 1'b0)
    `CHK(rdy_n, 1'b1)
    `CHK(cfg2, RST_CONFIG_TWO)
    `CHK({a1_oe, a2_oe, cont}, 3'h0)
    $display("test reset done");
    wr(ADDR_ELOFF_CTRL, 8'h10, 8'h00, 1'b0);
    wr(ADDR_CONFIG_TWO, 8'he0, 8'h00, 1'b0);
    wr(ADDR_ELOFF_SENSE, 8'h0f, 8'h00, 1'b0);
    `CHK(thr, 3'h0)
    `CHK(cfg2, 8'he0)
    `CHK(sense, 8'h0f)
    rd = 8'($urandom);
    wr(ADDR_ELOFF_CTRL, rd, 8'h00, 1'b0);
    `CHK(thr, rd[THRESH_HI:THRESH_LO])
    $display("test lead-off setup done");
    rb1 = 8'($urandom) | 8'h01;
    rb2 = 8'($urandom);
    wr(ADDR_BREATH_ONE, rb1, rb2, 1'b1);
    wr(ADDR_AUX, 8'h03, 8'h00, 1'b0);
    `CHK({src, a1_oe, a2_oe}, 3'h4)
    `CHK({demod_on, mod_on}, rb1[7:6])
    `CHK(freq, rb2[B2_FREQ_BIT])
    `CHK(ref_int, rb2[B2_REF_BIT])
    `CHK(pwr, rb2[B2_PWR_BIT])
    wr(ADDR_BREATH_ONE, rb1 & 8'hfe, 8'h00, 1'b0);
    `CHK({a1_oe, a2_oe, a1_o, a2_o}, 4'hf)
    wr(ADDR_BREATH_ONE, 8'h01, 8'h00, 1'b0);
    `CHK({a1_oe, a2_oe}, 2'h0)
    $display("test breath and aux done");
    i_host.sel();
    i_host.byte_out(OP_CONT_READ);
    i_host.desel();
    `CHK(cont, 1'b1)
    {ch1, ch2} = 48'({$urandom, $urandom});
    flags = 5'($urandom);
    {a1_drv, a2_drv} = 2'($urandom);
    fr = {STATUS_HEAD, flags, a2_drv, a1_drv, STATUS_PAD, ch1, ch2};
    repeat (4) @(negedge ref_clk);
    conv_done = 1'b1;
    @(negedge ref_clk);
    conv_done = 1'b0;
    {a1_drv, a2_drv} = ~{a1_drv, a2_drv};
    repeat (4) @(negedge ref_clk);
    `CHK(rdy_n, 1'b0)
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      exp_q.push_back(fr[i]);
    end
    for (int i = FRAME_BITS - 1; i >= FRAME_BITS - 8; i--) begin
      exp_q.push_back(fr[i]);
    end
    i_host.sel();
    `CHK(dout_oe, 1'b1)
    repeat (10) i_host.byte_out(8'h00);
    `CHK(rdy_n, 1'b1)
    i_host.desel();
    `CHK(dout_oe, 1'b0)
    `CHK(exp_q.size(), 0)
    $display("test frame read done");
    i_host.sel();
    i_host.byte_out(OP_STOP_READ);
    i_host.desel();
    `CHK(cont, 1'b0)
    i_host.sel();
    repeat (3) i_host.bit_out(1'b1);
    i_host.desel();
    wr(ADDR_ELOFF_CTRL, ~rd, 8'h00, 1'b0);
    `CHK(thr, ~rd[THRESH_HI:THRESH_LO])
    $display("test stop and recovery done");
    close_out();
  end
endmodule : test_afe_serial_control_port

/* File: rtl/asc_pkg.sv */
// Constants for the serial control port of the two-channel converter.
// Assumes the device master clock is the same as ref_clk.
package asc_pkg;

  // Clock rates and pace-flag lead time
  localparam int REF_CLK_MHZ    = 200;
  localparam int MCLK_MHZ       = 200;
  localparam int PACE_LEAD_TCLK = 2;
  localparam int PACE_LEAD_CYC  = PACE_LEAD_TCLK * REF_CLK_MHZ / MCLK_MHZ;

  // Output frame layout
  localparam int         FRAME_BITS  = 72;
  localparam logic [6:0] FRAME_LAST  = 7'h47;
  localparam logic [3:0] STATUS_HEAD = 4'hc;
  localparam logic [12:0] STATUS_PAD = 13'h0000;
  localparam int         FR_PACE_HI  = 62;
  localparam int         FR_PACE_LO  = 61;

  // Command opcodes
  localparam logic [7:0] OP_CONT_READ  = 8'h10;
  localparam logic [7:0] OP_STOP_READ  = 8'h11;
  localparam logic [2:0] OP_WRITE_HEAD = 3'h2;

  // Register addresses
  localparam logic [4:0] ADDR_CONFIG_TWO  = 5'h02;
  localparam logic [4:0] ADDR_ELOFF_CTRL  = 5'h04;
  localparam logic [4:0] ADDR_ELOFF_SENSE = 5'h06;
  localparam logic [4:0] ADDR_BREATH_ONE  = 5'h09;
  localparam logic [4:0] ADDR_BREATH_TWO  = 5'h0a;
  localparam logic [4:0] ADDR_AUX         = 5'h0b;

  // Reset values
  localparam logic [7:0] RST_CONFIG_TWO  = 8'h80;
  localparam logic [7:0] RST_ELOFF_CTRL  = 8'h00;
  localparam logic [7:0] RST_ELOFF_SENSE = 8'h00;
  localparam logic [7:0] RST_BREATH_ONE  = 8'h00;
  localparam logic [7:0] RST_BREATH_TWO  = 8'h00;
  localparam logic [7:0] RST_AUX         = 8'h0c;

  // Field positions
  localparam int B1_DEMOD_BIT = 7;
  localparam int B1_MOD_BIT   = 6;
  localparam int B1_SRC_BIT   = 0;
  localparam int B2_PWR_BIT   = 5;
  localparam int B2_FREQ_BIT  = 2;
  localparam int B2_REF_BIT   = 1;
  localparam int THRESH_HI    = 7;
  localparam int THRESH_LO    = 5;
  localparam int AUX_DIR_ONE  = 2;
  localparam int AUX_DIR_TWO  = 3;
  localparam int AUX_LVL_ONE  = 0;
  localparam int AUX_LVL_TWO  = 1;

  // Synchroniser bit positions and reset pattern
  localparam int          SY_CS    = 0;
  localparam int          SY_SCLK  = 1;
  localparam int          SY_DIN   = 2;
  localparam int          SY_AUX1  = 3;
  localparam int          SY_AUX2  = 4;
  localparam logic [4:0]  SY_RESET = 5'h01;

  typedef enum logic [1:0] {ST_OPCODE, ST_COUNT, ST_DATA} asc_state_type;

endpackage : asc_pkg

/* File: rtl/asc_port.sv */
// Serial host port with frame output, register writes and pin control.
// Assumes the host keeps its own timing duties; pins are asynchronous.
//
// Functional notes
// - Select high resets receiver and shifter, floats out
// - Ready falls on new data regardless of select
// - External breath clock forces aux pins input
// - Internal breath clock leaves aux pins free
// - Separate modulator, demodulator enables, frequency field
// - Aux levels sampled two clocks before ready
// - Reference select bit picks drive loop reference
// - Power bit turns drive amplifier on
// - Electrode-off comparator uses threshold bits seven-five
// - Data-in captured on serial clock falling edge
// - Data-out shifts on rising edge, MSB first
`timescale 1ns/1ps
module asc_port
  import asc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Serial pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  output logic             dout_o,
  output logic             dout_oe,
  output logic             sample_ready_n,
  // Conversion data
  input  wire logic        conv_done,
  input  wire logic [23:0] chan_one_data,
  input  wire logic [23:0] chan_two_data,
  input  wire logic [4:0]  electrode_off_flags,
  // Auxiliary pins
  input  wire logic        aux_pin_one_i,
  output logic             aux_pin_one_o,
  output logic             aux_pin_one_oe,
  input  wire logic        aux_pin_two_i,
  output logic             aux_pin_two_o,
  output logic             aux_pin_two_oe,
  // Settings
  output logic             breath_clock_source,
  output logic             breath_modulator_on,
  output logic             breath_demodulator_on,
  output logic             breath_mod_freq_sel,
  output logic             drive_ref_internal_sel,
  output logic             drive_amp_power_on,
  output logic [2:0]       electrode_off_threshold,
  output logic [7:0]       config_two,
  output logic [7:0]       electrode_off_sense_sel,
  output logic             cont_read_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edges

  logic [4:0]    sync_w;
  logic          sclk_d_r;
  logic          cs_s;
  logic          din_s;
  logic          sclk_rise;
  logic          sclk_fall;

  asc_sync #(.WIDTH(5), .RST_VAL(SY_RESET)) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .pin_in   ({aux_pin_two_i, aux_pin_one_i, din, sclk, cs_n}),
    .pin_sync (sync_w)
  );

  assign cs_s      = sync_w[SY_CS];
  assign din_s     = sync_w[SY_DIN];
  assign sclk_rise = sync_w[SY_SCLK] & ~sclk_d_r;
  assign sclk_fall = ~sync_w[SY_SCLK] & sclk_d_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sync_w[SY_SCLK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command receiver

  asc_state_type state_r;
  logic [2:0]    bit_cnt_r;
  logic [7:0]    rx_r;
  logic [7:0]    rx_nxt;
  logic [7:0]    cnt_r;
  logic [4:0]    wr_addr_r;
  logic [7:0]    wr_data_r;
  logic          wr_en_r;
  logic          byte_done;

  assign rx_nxt    = {rx_r[6:0], din_s};
  assign byte_done = sclk_fall & ~cs_s & (bit_cnt_r == 3'h7);

  always_ff @(posedge ref_clk) begin
    if (sys_rst || cs_s) begin
      state_r   <= ST_OPCODE;
      bit_cnt_r <= 3'h0;
      rx_r      <= 8'h00;
      cnt_r     <= 8'h00;
      wr_addr_r <= 5'h00;
      wr_data_r <= 8'h00;
      wr_en_r   <= 1'b0;
    end else begin
      wr_en_r <= 1'b0;
      if (wr_en_r) begin
        wr_addr_r <= wr_addr_r + 5'h01;
      end
      if (sclk_fall) begin
        rx_r      <= rx_nxt;
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if (byte_done) begin
        case (state_r)
          ST_OPCODE: begin
            if (rx_nxt[7:5] == OP_WRITE_HEAD) begin
              wr_addr_r <= rx_nxt[4:0];
              state_r   <= ST_COUNT;
            end
          end
          ST_COUNT: begin
            cnt_r   <= rx_nxt;
            state_r <= ST_DATA;
          end
          ST_DATA: begin
            wr_en_r   <= 1'b1;
            wr_data_r <= rx_nxt;
            if (cnt_r == 8'h00) begin
              state_r <= ST_OPCODE;
            end else begin
              cnt_r <= cnt_r - 8'h01;
            end
          end
          default: begin
            state_r <= ST_OPCODE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cont_read_active <= 1'b0;
    end else if (byte_done && state_r == ST_OPCODE) begin
      if (rx_nxt == OP_CONT_READ) begin
        cont_read_active <= 1'b1;
      end else if (rx_nxt == OP_STOP_READ) begin
        cont_read_active <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setting registers

  logic [7:0] eloff_ctrl_r;
  logic [7:0] breath_one_r;
  logic [7:0] breath_two_r;
  logic [7:0] aux_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      config_two              <= RST_CONFIG_TWO;
      eloff_ctrl_r            <= RST_ELOFF_CTRL;
      electrode_off_sense_sel <= RST_ELOFF_SENSE;
      breath_one_r            <= RST_BREATH_ONE;
      breath_two_r            <= RST_BREATH_TWO;
      aux_r                   <= RST_AUX;
    end else if (wr_en_r) begin
      case (wr_addr_r)
        ADDR_CONFIG_TWO:  config_two              <= wr_data_r;
        ADDR_ELOFF_CTRL:  eloff_ctrl_r            <= wr_data_r;
        ADDR_ELOFF_SENSE: electrode_off_sense_sel <= wr_data_r;
        ADDR_BREATH_ONE:  breath_one_r            <= wr_data_r;
        ADDR_BREATH_TWO:  breath_two_r            <= wr_data_r;
        ADDR_AUX:         aux_r                   <= wr_data_r;
        default:          aux_r                   <= aux_r;
      endcase
    end
  end

  assign electrode_off_threshold = eloff_ctrl_r[THRESH_HI:THRESH_LO];
  assign breath_clock_source    = breath_one_r[B1_SRC_BIT];
  assign breath_modulator_on    = breath_one_r[B1_MOD_BIT];
  assign breath_demodulator_on  = breath_one_r[B1_DEMOD_BIT];
  assign breath_mod_freq_sel    = breath_two_r[B2_FREQ_BIT];
  assign drive_ref_internal_sel = breath_two_r[B2_REF_BIT];
  assign drive_amp_power_on     = breath_two_r[B2_PWR_BIT];

  // Auxiliary pin drivers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aux_pin_one_oe <= 1'b0;
      aux_pin_two_oe <= 1'b0;
      aux_pin_one_o  <= 1'b0;
      aux_pin_two_o  <= 1'b0;
    end else begin
      aux_pin_one_oe <= ~breath_clock_source & ~aux_r[AUX_DIR_ONE];
      aux_pin_two_oe <= ~breath_clock_source & ~aux_r[AUX_DIR_TWO];
      aux_pin_one_o  <= aux_r[AUX_LVL_ONE];
      aux_pin_two_o  <= aux_r[AUX_LVL_TWO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame capture and ready

  logic [1:0]  lead_cnt_r;
  logic [1:0]  pace_r;
  logic [4:0]  flags_r;
  logic [23:0] ch1_r;
  logic [23:0] ch2_r;
  logic [71:0] frame_r;
  logic        ready_fire;

  assign ready_fire = (lead_cnt_r == 2'h1);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lead_cnt_r <= 2'h0;
      pace_r     <= 2'h0;
      flags_r    <= 5'h00;
      ch1_r      <= 24'h000000;
      ch2_r      <= 24'h000000;
    end else if (conv_done) begin
      lead_cnt_r <= 2'(PACE_LEAD_CYC);
      pace_r     <= {sync_w[SY_AUX2], sync_w[SY_AUX1]};
      flags_r    <= electrode_off_flags;
      ch1_r      <= chan_one_data;
      ch2_r      <= chan_two_data;
    end else if (lead_cnt_r != 2'h0) begin
      lead_cnt_r <= lead_cnt_r - 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      frame_r <= 72'h0;
    end else if (ready_fire) begin
      frame_r <= {STATUS_HEAD, flags_r, pace_r, STATUS_PAD, ch1_r, ch2_r};
    end
  end

  // New data wins over the clearing clock edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sample_ready_n <= 1'b1;
    end else if (ready_fire) begin
      sample_ready_n <= 1'b0;
    end else if (sclk_fall) begin
      sample_ready_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-out shifter

  logic [6:0] out_idx_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || cs_s) begin
      dout_oe   <= 1'b0;
      dout_o    <= 1'b0;
      out_idx_r <= 7'h00;
    end else begin
      dout_oe <= 1'b1;
      if (sclk_rise) begin
        dout_o    <= cont_read_active & frame_r[FRAME_LAST - out_idx_r];
        out_idx_r <= (out_idx_r == FRAME_LAST) ? 7'h00 : out_idx_r + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_cs_high_float: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cs_s |=> !dout_oe)
    else $error("data-out driven while deselected");

  a_deselect_resets: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cs_s |=> (bit_cnt_r == 3'h0) && (state_r == ST_OPCODE))
    else $error("receiver not reset by deselect");

  a_ready_on_done: assert property (@(posedge ref_clk) disable iff (sys_rst)
    conv_done |-> ##3 !sample_ready_n)
    else $error("ready did not fall three cycles after conversion");

  a_ready_clear_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sclk_fall && !ready_fire |=> sample_ready_n)
    else $error("ready not released on clock fall");

  a_aux_forced_in: assert property (@(posedge ref_clk) disable iff (sys_rst)
    breath_clock_source ##1 breath_clock_source
      |-> !aux_pin_one_oe && !aux_pin_two_oe)
    else $error("aux pin driven under external breath clock");

  a_din_capture: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sclk_fall && !cs_s |=> rx_r[0] == $past(din_s))
    else $error("data-in bit not captured on falling edge");

  a_dout_msb_first: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sclk_rise && !cs_s && cont_read_active && out_idx_r == 7'h00
      |=> dout_o == $past(frame_r[71]))
    else $error("first data-out bit is not the MSB");

  a_pace_sample: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ready_fire && !$past(conv_done)
      |=> frame_r[FR_PACE_HI:FR_PACE_LO] == $past(pace_r))
    else $error("pace bits not loaded with ready");

  a_thresh_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_en_r && wr_addr_r == ADDR_ELOFF_CTRL
      |=> electrode_off_threshold == $past(wr_data_r[7:5]))
    else $error("threshold not taken from control write");

endmodule : asc_port

/* File: rtl/asc_sync.sv */
// Two-flop synchroniser for a group of pins.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
module asc_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Pins and synchronised copies
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_r   <= RST_VAL;
      pin_sync <= RST_VAL;
    end else begin
      meta_r   <= pin_in;
      pin_sync <= meta_r;
    end
  end

endmodule : asc_sync
